//--- csl_verify_xnor.sv
/*
  code security lock package and the verification scrambler.
  assumes one clock domain; the scrambler is pure logic fed by the
  lock top, which registers its result before it reaches any pin.
*/
package csl_pkg;
  localparam int CSL_ADDR_W = 13;
  localparam int CSL_CODE_DEPTH = 8192;
  localparam int CSL_ENC_W = 6;
  localparam int CSL_ENC_DEPTH = 64;
  localparam int CSL_SYNC_STAGES = 2;
  localparam int CSL_TRANS_ACT = 1;
  // register byte offsets
  localparam logic [7:0] OFF_LOCK = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PROG_ADDR = 8'h08;
  localparam logic [7:0] OFF_PROG_DATA = 8'h0c;
  localparam logic [7:0] OFF_SIGNATURE = 8'h10;
  localparam logic [7:0] OFF_ENC_TABLE = 8'h14;
  // status field positions
  localparam int ST_PROG_REFUSED = 0;
  localparam int ST_VERIFY_BLOCKED = 1;
  localparam int ST_ENC_PROGRAMMED = 2;
  localparam int ST_EA_LATCHED = 3;
  localparam int ST_LEVEL_LSB = 4;
  // lock field positions
  localparam int LK_ONE = 0;
  localparam int LK_TWO = 1;
  localparam int LK_THREE = 2;
  // signature locations
  localparam logic [12:0] SIG_LOC_MAKER = 13'h030;
  localparam logic [12:0] SIG_LOC_PART = 13'h031;
  localparam logic [12:0] SIG_LOC_REV = 13'h060;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] LOCK_RESET = 3'h7;

  typedef enum logic [1:0] {
    CSL_LVL_NONE,
    CSL_LVL_ONE,
    CSL_LVL_TWO,
    CSL_LVL_THREE
  } csl_level_e;

  // highest lock bit set decides the level
  function automatic csl_level_e csl_level(input logic [2:0] lk);
    if (lk[LK_THREE]) return CSL_LVL_THREE;
    else if (lk[LK_TWO]) return CSL_LVL_TWO;
    else if (lk[LK_ONE]) return CSL_LVL_ONE;
    else return CSL_LVL_NONE;
  endfunction

  // verify is open only while bits two and three are clear
  function automatic logic csl_verify_ok(input logic [2:0] lk);
    return !(lk[LK_TWO] || lk[LK_THREE]);
  endfunction
endpackage

`timescale 1ns/1ps
module csl_verify_xnor
  import csl_pkg::*;
(
  input wire logic [7:0] code_byte,
  input wire logic [7:0] key_byte,
  input wire logic enc_programmed,
  output logic [7:0] verify_byte
);
  always_comb begin
    if (enc_programmed) begin
      verify_byte = ~(code_byte ^ key_byte);
    end else begin
      verify_byte = code_byte;
    end
  end
endmodule // csl_verify_xnor

//--- csl_lock.sv
/*
  code security lock: program memory, encryption table, lock levels,
  ahb-lite register slave and the code-read gate for the core.
  assumes lock bit pins are static fuse levels, the access select pin
  is asynchronous, and the core request port runs on hclk.
*/
`timescale 1ns/1ps
module csl_lock
  import csl_pkg::*;
#(
  parameter int CODE_DEPTH = CSL_CODE_DEPTH,
  parameter int ENC_DEPTH = CSL_ENC_DEPTH,
  // identity values are arbitrary
  parameter logic [7:0] SIG_MAKER = 8'h5a,
  parameter logic [7:0] SIG_PART = 8'ha3,
  parameter logic [7:0] SIG_REV = 8'h07
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic lock_bit_one,
  input wire logic lock_bit_two,
  input wire logic lock_bit_three,
  input wire logic external_access_select,
  input wire logic ctr_req,
  input wire logic ctr_from_ext,
  input wire logic [CSL_ADDR_W-1:0] ctr_addr,
  output logic ctr_valid,
  output logic ctr_denied,
  output logic [7:0] ctr_data,
  output logic ea_effective,
  output logic ext_exec_enable
);
  // refuse depths that differ from what the address widths reach
  if (CODE_DEPTH != (1 << CSL_ADDR_W)
      || ENC_DEPTH != (1 << CSL_ENC_W)) begin : g_bad_depth
    $error("csl_lock: memory depth does not match address width");
  end

  logic [7:0] code_mem [CODE_DEPTH];
  logic [7:0] enc_tbl [ENC_DEPTH];
  logic [CSL_SYNC_STAGES-1:0] lk_sync [3];
  logic [CSL_SYNC_STAGES-1:0] ea_sync;
  logic [2:0] lock_s;
  logic ea_s;
  logic dp_valid, next_dp_valid;
  logic dp_write, next_dp_write;
  logic [7:0] dp_off, next_dp_off;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic [CSL_ADDR_W-1:0] prog_addr, next_prog_addr;
  logic prog_refused, next_prog_refused;
  logic verify_blocked, next_verify_blocked;
  logic enc_prog, next_enc_prog;
  logic ea_latched, next_ea_latched;
  logic ea_caught, next_ea_caught;
  logic [1:0] settle, next_settle;
  logic next_ctr_valid, next_ctr_denied;
  logic [7:0] next_ctr_data;
  logic next_ea_effective, next_ext_exec_enable;
  logic [7:0] code_rd, key_rd, verify_byte, sig_byte;
  logic wr_prog, wr_enc, rd_phase;

  // pin synchronisers, reset to the most restrictive level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 3; i++) begin
        lk_sync[i] <= {CSL_SYNC_STAGES{LOCK_RESET[i]}};
      end
      ea_sync <= '0;
    end else begin
      lk_sync[LK_ONE] <= {lk_sync[LK_ONE][0], lock_bit_one};
      lk_sync[LK_TWO] <= {lk_sync[LK_TWO][0], lock_bit_two};
      lk_sync[LK_THREE] <= {lk_sync[LK_THREE][0], lock_bit_three};
      ea_sync <= {ea_sync[0], external_access_select};
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_lock
      assign lock_s[g] = lk_sync[g][CSL_SYNC_STAGES-1];
    end
  endgenerate
  assign ea_s = ea_sync[CSL_SYNC_STAGES-1];

  assign code_rd = code_mem[prog_addr];
  assign key_rd = enc_tbl[prog_addr[CSL_ENC_W-1:0]];
  assign rd_phase = dp_valid && !dp_write;
  assign wr_prog = dp_valid && dp_write && dp_off == OFF_PROG_DATA;
  assign wr_enc = dp_valid && dp_write && dp_off == OFF_ENC_TABLE;

  csl_verify_xnor u_xnor (
    .code_byte(code_rd),
    .key_byte(key_rd),
    .enc_programmed(enc_prog),
    .verify_byte(verify_byte)
  );

  always_comb begin
    unique case (prog_addr)
      SIG_LOC_MAKER: sig_byte = SIG_MAKER;
      SIG_LOC_PART: sig_byte = SIG_PART;
      SIG_LOC_REV: sig_byte = SIG_REV;
      default: sig_byte = ZERO_BYTE;
    endcase
  end

  // bus slave, program path and protection outputs
  always_comb begin
    next_dp_valid = hsel && htrans[CSL_TRANS_ACT] && hready;
    next_dp_write = hwrite;
    next_dp_off = haddr[7:0];
    next_hreadyout = !(next_dp_valid && !hwrite);
    next_hrdata = hrdata;
    next_prog_addr = prog_addr;
    next_prog_refused = prog_refused;
    next_verify_blocked = verify_blocked;
    next_enc_prog = enc_prog;
    if (dp_valid && dp_write) begin
      unique case (dp_off)
        OFF_STATUS: begin
          if (hwdata[ST_PROG_REFUSED]) next_prog_refused = 1'b0;
          if (hwdata[ST_VERIFY_BLOCKED]) next_verify_blocked = 1'b0;
        end
        OFF_PROG_ADDR: next_prog_addr = hwdata[CSL_ADDR_W-1:0];
        OFF_PROG_DATA: if (lock_s[LK_ONE]) next_prog_refused = 1'b1;
        OFF_ENC_TABLE: next_enc_prog = 1'b1;
        default: ;
      endcase
    end
    if (rd_phase) begin
      next_hrdata = '0;
      unique case (dp_off)
        OFF_LOCK: next_hrdata[2:0] = lock_s;
        OFF_STATUS: begin
          next_hrdata[ST_PROG_REFUSED] = prog_refused;
          next_hrdata[ST_VERIFY_BLOCKED] = verify_blocked;
          next_hrdata[ST_ENC_PROGRAMMED] = enc_prog;
          next_hrdata[ST_EA_LATCHED] = ea_latched;
          next_hrdata[ST_LEVEL_LSB +: 2] = csl_level(lock_s);
        end
        OFF_PROG_ADDR: next_hrdata[CSL_ADDR_W-1:0] = prog_addr;
        OFF_PROG_DATA: begin
          if (csl_verify_ok(lock_s)) next_hrdata[7:0] = verify_byte;
          else next_verify_blocked = 1'b1;
        end
        OFF_SIGNATURE: next_hrdata[7:0] = sig_byte;
        default: next_hrdata = '0;
      endcase
    end
    next_settle = settle;
    next_ea_caught = ea_caught;
    next_ea_latched = ea_latched;
    if (!ea_caught) begin
      if (settle == 2'(CSL_SYNC_STAGES)) begin
        next_ea_caught = 1'b1;
        next_ea_latched = ea_s;
      end else begin
        next_settle = settle + 2'd1;
      end
    end
    next_ea_effective = lock_s[LK_ONE] ? ea_latched : ea_s;
    next_ext_exec_enable = csl_level(lock_s) != CSL_LVL_THREE;
    next_ctr_valid = ctr_req;
    next_ctr_denied = ctr_req && ctr_from_ext && lock_s[LK_ONE];
    next_ctr_data = ZERO_BYTE;
    if (ctr_req && !next_ctr_denied) next_ctr_data = code_mem[ctr_addr];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_off <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
      prog_addr <= '0;
      prog_refused <= 1'b0;
      verify_blocked <= 1'b0;
      enc_prog <= 1'b0;
      ea_latched <= 1'b0;
      ea_caught <= 1'b0;
      settle <= '0;
      ctr_valid <= 1'b0;
      ctr_denied <= 1'b0;
      ctr_data <= '0;
      ea_effective <= 1'b0;
      ext_exec_enable <= 1'b0;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_off <= next_dp_off;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      prog_addr <= next_prog_addr;
      prog_refused <= next_prog_refused;
      verify_blocked <= next_verify_blocked;
      enc_prog <= next_enc_prog;
      ea_latched <= next_ea_latched;
      ea_caught <= next_ea_caught;
      settle <= next_settle;
      ctr_valid <= next_ctr_valid;
      ctr_denied <= next_ctr_denied;
      ctr_data <= next_ctr_data;
      ea_effective <= next_ea_effective;
      ext_exec_enable <= next_ext_exec_enable;
    end
  end

  // memories: erased table bytes read as all ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ENC_DEPTH; i++) begin
        enc_tbl[i] <= ERASED_BYTE;
      end
    end else if (wr_enc) begin
      enc_tbl[prog_addr[CSL_ENC_W-1:0]] <= hwdata[7:0];
    end
  end

  // program only while lock one clear
  always_ff @(posedge hclk) begin
    if (wr_prog && !lock_s[LK_ONE]) begin
      code_mem[prog_addr] <= hwdata[7:0];
    end
  end

  logic [7:0] exp_xnor;
  assign exp_xnor = ~(code_rd ^ key_rd);

  a_sig_maker: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_phase && dp_off == OFF_SIGNATURE && prog_addr == SIG_LOC_MAKER
    |=> hrdata == {24'h0, SIG_MAKER})
    else $error("signature maker byte wrong");
  a_verify_open: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_phase && dp_off == OFF_PROG_DATA && lock_s == 3'h0 && !enc_prog
    |=> hrdata[7:0] == $past(code_rd) && hreadyout == 1'b1)
    else $error("plain verify byte wrong");
  a_verify_xnor: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_phase && dp_off == OFF_PROG_DATA && csl_verify_ok(lock_s)
    && enc_prog |=> hrdata[7:0] == $past(exp_xnor))
    else $error("encrypted verify byte wrong");
  a_enc_hidden: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_phase && dp_off == OFF_ENC_TABLE |=> hrdata == 32'h0)
    else $error("encryption table leaked");
  a_ctr_block: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctr_req && ctr_from_ext && lock_s[LK_ONE]
    |=> ctr_valid && ctr_denied && ctr_data == 8'h00)
    else $error("external code-table read not blocked");
  a_ea_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ea_caught && lock_s[LK_ONE] |=> $stable(ea_latched)
    ##1 ea_effective == $past(ea_latched))
    else $error("latched access select moved");
  a_prog_refuse: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_prog && lock_s[LK_ONE] |=> prog_refused)
    else $error("program write not refused");
  a_verify_lock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_phase && dp_off == OFF_PROG_DATA && lock_s[LK_TWO]
    |=> hrdata == 32'h0 && verify_blocked)
    else $error("verify not blocked");
  a_ext_exec: assert property (
    @(posedge hclk) disable iff (!hresetn)
    lock_s[LK_THREE] |=> !ext_exec_enable)
    else $error("external execution allowed");
  a_reset_safe: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(dp_valid) && $past(lock_s) == LOCK_RESET |-> !ext_exec_enable)
    else $error("restriction missing after reset");
endmodule // csl_lock

//--- csl_prog_model.sv
/*
  programming system model: single-word ahb-lite master transfers.
  assumes hready is the one slave's hreadyout and that each task is
  entered just after a rising edge of hclk.
*/
`timescale 1ns/1ps
module csl_prog_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // address phase, then data phase; released lines are inverted
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~{24'h000000, a};
    hwrite <= ~wr;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // csl_prog_model

//--- csl_lock_tb.sv
/*
  self-checking bench for the code security lock.
  assumes the programming model is the only bus master and that lock
  pins change only while reset is held.
*/
`timescale 1ns/1ps
module csl_lock_tb
  import csl_pkg::*;
();
  typedef struct packed {
    logic [2:0] lk;
    logic [7:0] wd;
    logic [7:0] vfy;
    logic [7:0] sts;
    logic den;
    logic exe;
    logic ea;
  } csl_row_s;
  // identity values are arbitrary
  localparam logic [7:0] SIG_A = 8'h6b;
  localparam logic [7:0] SIG_B = 8'hd4;
  localparam logic [7:0] SIG_C = 8'h2e;
  logic hclk, hresetn, hsel, hwrite, hready, lk1, lk2, lk3, ea_pin;
  logic ctr_req, ctr_from_ext, ctr_valid, ctr_denied, ea_eff, exe_en, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [12:0] ctr_addr;
  logic [7:0] ctr_data;
  logic [9:0] cv;
  int failures, check_count;
  logic [12:0] sig_loc [3] = '{SIG_LOC_MAKER, SIG_LOC_PART, SIG_LOC_REV};
  logic [7:0] sig_val [3] = '{SIG_A, SIG_B, SIG_C};
  // only the four listed lock combinations
  csl_row_s rows [4] = '{
    '{3'h0, 8'h3c, 8'h3c, 8'h00, 1'b0, 1'b1, 1'b0},
    '{3'h1, 8'ha5, 8'h3c, 8'h11, 1'b1, 1'b1, 1'b1},
    '{3'h3, 8'ha5, 8'h00, 8'h23, 1'b1, 1'b1, 1'b1},
    '{3'h7, 8'ha5, 8'h00, 8'h33, 1'b1, 1'b0, 1'b1}};

  csl_lock #(.SIG_MAKER(SIG_A), .SIG_PART(SIG_B), .SIG_REV(SIG_C)) u_csl_lock (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .lock_bit_one(lk1), .lock_bit_two(lk2), .lock_bit_three(lk3),
    .external_access_select(ea_pin), .ctr_req(ctr_req),
    .ctr_from_ext(ctr_from_ext), .ctr_addr(ctr_addr),
    .ctr_valid(ctr_valid), .ctr_denied(ctr_denied), .ctr_data(ctr_data),
    .ea_effective(ea_eff), .ext_exec_enable(exe_en));

  csl_prog_model u_csl_prog_model (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_csl_prog_model.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a);
    u_csl_prog_model.xfer(1'b0, a, 32'h0, rv);
  endtask

  // one code-table read; cv packs valid, denied and data
  task automatic ctr_rd(input logic ext, input logic [12:0] a);
    ctr_req <= 1'b1;
    ctr_from_ext <= ext;
    ctr_addr <= a;
    @(posedge hclk);
    ctr_req <= 1'b0;
    #1;
    cv = {ctr_valid, ctr_denied, ctr_data};
    @(posedge hclk);
  endtask

  task automatic do_reset(input logic [2:0] lk);
    hresetn <= 1'b0;
    {lk3, lk2, lk1} <= lk;
    ea_pin <= 1'b1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    failures++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    {lk3, lk2, lk1, ea_pin} = 4'h0;
    {ctr_req, ctr_from_ext, ctr_addr} = 15'h0;
    failures = 0;
    check_count = 0;
    for (int i = 0; i < 4; i++) begin
      do_reset(rows[i].lk);
      rd(OFF_LOCK);
      chk(rv, 32'(rows[i].lk));
      wr(OFF_PROG_ADDR, 32'h10);
      wr(OFF_PROG_DATA, 32'(rows[i].wd));
      chk(32'(hresp), 32'h0);
      rd(OFF_PROG_DATA);
      chk(rv, 32'(rows[i].vfy));
      rd(OFF_STATUS);
      chk(rv & 32'h33, 32'(rows[i].sts));
      wr(OFF_STATUS, 32'h3);
      rd(OFF_STATUS);
      chk(rv & 32'h3b, 32'(rows[i].sts & 8'h30) | 32'h8);
      ctr_rd(1'b1, 13'h010);
      chk(32'(cv), 32'({1'b1, rows[i].den,
        rows[i].den ? 8'h00 : 8'h3c}));
      ctr_rd(1'b0, 13'h010);
      chk(32'(cv), 32'h23c);
      chk(32'(exe_en), 32'(rows[i].exe));
      ea_pin <= 1'b0;
      repeat (6) @(posedge hclk);
      chk(32'(ea_eff), 32'(rows[i].ea));
      $display("lock row %0d done", i);
    end
    do_reset(3'h0);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_PROG_ADDR, 32'(sig_loc[i]));
      rd(OFF_SIGNATURE);
      chk(rv, 32'(sig_val[i]));
    end
    wr(OFF_PROG_ADDR, 32'h10);
    rd(OFF_PROG_ADDR);
    chk(rv, 32'h10);
    wr(OFF_ENC_TABLE, 32'h0f);
    rd(OFF_PROG_DATA);
    chk(rv, {24'h0, ~(8'h3c ^ 8'h0f)});
    rd(OFF_ENC_TABLE);
    chk(rv, 32'h0);
    rd(8'h20);
    chk(rv, 32'h0);
    rd(OFF_STATUS);
    chk(rv & 32'h4, 32'h4);
    wr(OFF_LOCK, 32'h7);
    rd(OFF_LOCK);
    chk(rv, 32'h0);
    $display("signature and encryption done");
    wr(OFF_PROG_ADDR, 32'h11);
    wr(OFF_PROG_DATA, 32'hc3);
    ctr_req <= 1'b1;
    ctr_from_ext <= 1'b1;
    ctr_addr <= 13'h010;
    @(posedge hclk);
    ctr_addr <= 13'h011;
    #1;
    chk(32'({ctr_valid, ctr_denied, ctr_data}), 32'h23c);
    @(posedge hclk);
    ctr_req <= 1'b0;
    #1;
    chk(32'({ctr_valid, ctr_denied, ctr_data}), 32'h2c3);
    $display("back to back reads done");
    print_verdict();
  end
endmodule // csl_lock_tb
